/* File: rtl/pdvo_video_out.sv */
// Pixel bus, pixel clock, sync, blank and palette strobe output logic
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
module pdvo_video_out #(
  parameter int PIX_W = 8
) (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Register port
  input wire logic [pdvo_pkg::REG_AW-1:0] i_reg_addr,
  input wire logic [pdvo_pkg::REG_DW-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [pdvo_pkg::REG_DW-1:0] o_reg_rdata,
  // Video clock pins
  input wire logic i_video_clock_in_a,
  input wire logic i_video_clock_in_b,
  input wire logic i_video_clock_in_c,
  // Pixel and timing from display logic
  input wire logic [PIX_W-1:0] i_pixel,
  input wire pdvo_pkg::pdvo_timing_s i_timing,
  output logic o_pixel_take,
  // Host I/O cycle
  input wire pdvo_pkg::pdvo_io_s i_io,
  // DAC side
  output logic [PIX_W-1:0] o_pixel_bus_out,
  output logic o_pixel_oe,
  output logic o_pclk,
  output logic o_palette_read_strobe_n,
  output logic o_palette_write_strobe_n,
  // Monitor side
  output logic o_blank_out_n,
  output logic o_hsync,
  output logic o_vsync,
  output logic o_ctl_oe
);

  // ****************************************************
  // Elaboration checks
  // ****************************************************
  if (PIX_W != 8) begin : g_bad_width
    $error("Pixel width must be eight");
  end

  // ****************************************************
  // Functions
  // ****************************************************
  function automatic logic pal_read_hit(input logic [15:0] a);
    pal_read_hit = (a == pdvo_pkg::PAL_MASK_ADDR) ||
                   (a == pdvo_pkg::PAL_WIDX_ADDR) ||
                   (a == pdvo_pkg::PAL_DATA_ADDR);
  endfunction

  function automatic logic pal_write_hit(input logic [15:0] a);
    pal_write_hit = (a >= pdvo_pkg::PAL_MASK_ADDR) &&
                    (a <= pdvo_pkg::PAL_DATA_ADDR);
  endfunction

  function automatic logic pick_clock(input logic [2:0] lvl,
                                      input logic [1:0] sel);
    case (sel)
      pdvo_pkg::CLK_SEL_B: pick_clock = lvl[1];
      pdvo_pkg::CLK_SEL_C: pick_clock = lvl[2];
      default: pick_clock = lvl[0];
    endcase
  endfunction

  // ****************************************************
  // Registers
  // ****************************************************
  logic [pdvo_pkg::REG_DW-1:0] misc_out;
  logic [pdvo_pkg::REG_DW-1:0] ext_ctrl4;
  logic [pdvo_pkg::REG_DW-1:0] mode;
  logic [pdvo_pkg::REG_DW-1:0] status;
  logic [pdvo_pkg::REG_DW-1:0] next_rdata;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      misc_out <= pdvo_pkg::MISC_OUT_RST;
      ext_ctrl4 <= pdvo_pkg::EXT_CTRL4_RST;
      mode <= pdvo_pkg::MODE_RST;
    end else if (i_ce && i_reg_wr) begin
      case (i_reg_addr)
        pdvo_pkg::OFS_MISC_OUT: misc_out <= i_reg_wdata;
        pdvo_pkg::OFS_EXT_CTRL4: ext_ctrl4 <= i_reg_wdata;
        pdvo_pkg::OFS_MODE: mode <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // Unmapped offsets read as zero
  always_comb begin
    case (i_reg_addr)
      pdvo_pkg::OFS_MISC_OUT: next_rdata = misc_out;
      pdvo_pkg::OFS_EXT_CTRL4: next_rdata = ext_ctrl4;
      pdvo_pkg::OFS_MODE: next_rdata = mode;
      pdvo_pkg::OFS_STATUS: next_rdata = status;
      default: next_rdata = '0;
    endcase
  end

  // Data stand for one cycle only, zero otherwise
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= '0;
    end else if (i_ce) begin
      o_reg_rdata <= i_reg_rd ? next_rdata : '0;
    end
  end

  // ****************************************************
  // Field decode
  // ****************************************************
  logic [1:0] clk_sel;
  logic half_mode;
  logic hpol_low;
  logic vpol_low;
  assign clk_sel = misc_out[pdvo_pkg::MISC_CLK_LSB +: 2];
  assign hpol_low = misc_out[pdvo_pkg::MISC_HPOL_BIT];
  assign vpol_low = misc_out[pdvo_pkg::MISC_VPOL_BIT];
  assign half_mode = mode[pdvo_pkg::MODE_HALF_BIT];

  // ****************************************************
  // Video clock synchronisers
  // ****************************************************
  // Pins are asynchronous; a level counts only once stages two and three
  // agree, which filters a single-cycle glitch at the cost of latency.
  logic [2:0] vclk_s1;
  logic [2:0] vclk_s2;
  logic [2:0] vclk_s3;
  logic [2:0] vclk_lvl;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      vclk_s1 <= 3'h0;
      vclk_s2 <= 3'h0;
      vclk_s3 <= 3'h0;
    end else if (i_ce) begin
      vclk_s1 <= {i_video_clock_in_c, i_video_clock_in_b,
                  i_video_clock_in_a};
      vclk_s2 <= vclk_s1;
      vclk_s3 <= vclk_s2;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      vclk_lvl <= 3'h0;
    end else if (i_ce) begin
      for (int i = 0; i < 3; i++) begin
        if (vclk_s2[i] == vclk_s3[i]) begin
          vclk_lvl[i] <= vclk_s3[i];
        end
      end
    end
  end

  // ****************************************************
  // Pixel clock
  // ****************************************************
  // Only video clocks well below a quarter of the master rate survive sampling.
  logic sel_now;
  logic sel_prev;
  logic sel_rise;
  logic next_pclk;
  logic pclk_fall;

  assign sel_now = pick_clock(vclk_lvl, clk_sel); // R3
  assign sel_rise = sel_now & ~sel_prev;

  always_comb begin
    if (half_mode) begin
      next_pclk = sel_rise ? ~o_pclk : o_pclk; // R4
    end else begin
      next_pclk = sel_now; // R4
    end
  end

  assign pclk_fall = o_pclk & ~next_pclk;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sel_prev <= 1'b0;
      o_pclk <= 1'b0;
    end else if (i_ce) begin
      sel_prev <= sel_now;
      o_pclk <= next_pclk; // R2
    end
  end

  // ****************************************************
  // Pixel bus
  // ****************************************************
  // Loaded on the falling pixel clock so it is settled at the rising edge.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pixel_bus_out <= '0;
      o_pixel_take <= 1'b0;
    end else if (i_ce) begin
      o_pixel_take <= pclk_fall; // R2
      if (pclk_fall) begin
        o_pixel_bus_out <= i_pixel; // R1
      end
    end
  end

  // ****************************************************
  // Blank and sync
  // ****************************************************
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_blank_out_n <= 1'b1;
      o_hsync <= 1'b0;
      o_vsync <= 1'b0;
    end else if (i_ce) begin
      o_blank_out_n <= ~i_timing.blank; // R7
      o_hsync <= i_timing.hsync ^ hpol_low; // R8
      o_vsync <= i_timing.vsync ^ vpol_low; // R9
    end
  end

  // ****************************************************
  // Test float enables
  // ****************************************************
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pixel_oe <= 1'b1;
      o_ctl_oe <= 1'b1;
    end else if (i_ce) begin
      o_pixel_oe <= ~ext_ctrl4[pdvo_pkg::EXT_PIX_TRI_BIT]; // R10
      o_ctl_oe <= ~ext_ctrl4[pdvo_pkg::EXT_CTL_TRI_BIT]; // R11
    end
  end

  // ****************************************************
  // Palette strobes
  // ****************************************************
  // A cycle showing both read and write is malformed; neither strobe fires.
  logic rd_hit;
  logic wr_hit;
  assign rd_hit = i_io.rd && !i_io.wr && pal_read_hit(i_io.addr); // R5 R12
  assign wr_hit = i_io.wr && !i_io.rd && pal_write_hit(i_io.addr); // R6 R12

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_palette_read_strobe_n <= 1'b1;
      o_palette_write_strobe_n <= 1'b1;
    end else if (i_ce) begin
      o_palette_read_strobe_n <= ~rd_hit; // R5
      o_palette_write_strobe_n <= ~wr_hit; // R6
    end
  end

  // ****************************************************
  // Status
  // ****************************************************
  assign status = {3'h0, o_palette_write_strobe_n, o_palette_read_strobe_n,
                   sel_now, half_mode, o_pclk};

  // ****************************************************
  // Assertions
  // ****************************************************
  sequence s_read_cycle;
    i_ce && rd_hit;
  endsequence

  sequence s_write_cycle;
    i_ce && wr_hit;
  endsequence

  property p_read_strobe;
    @(posedge i_mclk) disable iff (!i_resetn)
      s_read_cycle |=> !o_palette_read_strobe_n && o_palette_write_strobe_n;
  endproperty
  a_read_strobe: assert property (p_read_strobe) // R5
    else $error("Read strobe missing");
  property p_read_idle;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_ce && !(i_io.rd && pal_read_hit(i_io.addr))) |=>
        o_palette_read_strobe_n;
  endproperty
  a_read_idle: assert property (p_read_idle) // R5
    else $error("Read strobe without qualifying read");
  property p_write_strobe;
    @(posedge i_mclk) disable iff (!i_resetn)
      s_write_cycle |=> !o_palette_write_strobe_n && o_palette_read_strobe_n;
  endproperty
  a_write_strobe: assert property (p_write_strobe) // R6
    else $error("Write strobe missing");
  property p_write_idle;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_ce && !(i_io.wr && pal_write_hit(i_io.addr))) |=>
        o_palette_write_strobe_n;
  endproperty
  a_write_idle: assert property (p_write_idle) // R6
    else $error("Write strobe without qualifying write");
  property p_strobe_excl;
    @(posedge i_mclk) disable iff (!i_resetn)
      !(!o_palette_read_strobe_n && !o_palette_write_strobe_n);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl) // R12
    else $error("Both palette strobes low");
  property p_blank;
    @(posedge i_mclk) disable iff (!i_resetn)
      i_ce |=> o_blank_out_n == !$past(i_timing.blank);
  endproperty
  a_blank: assert property (p_blank) // R7
    else $error("Blank output wrong");
  property p_hsync;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_ce && !hpol_low && !(i_reg_wr && i_reg_addr ==
        pdvo_pkg::OFS_MISC_OUT)) |=> o_hsync == $past(i_timing.hsync);
  endproperty
  a_hsync: assert property (p_hsync) // R8
    else $error("Horizontal sync level wrong");
  property p_vsync;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_ce && vpol_low) |=> o_vsync == !$past(i_timing.vsync);
  endproperty
  a_vsync: assert property (p_vsync) // R9
    else $error("Vertical sync level wrong");
  property p_pix_float;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_ce && ext_ctrl4[pdvo_pkg::EXT_PIX_TRI_BIT]) |=> !o_pixel_oe;
  endproperty
  a_pix_float: assert property (p_pix_float) // R10
    else $error("Pixel bus not floated");
  property p_ctl_float;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_ce && !ext_ctrl4[pdvo_pkg::EXT_CTL_TRI_BIT]) |=> o_ctl_oe;
  endproperty
  a_ctl_float: assert property (p_ctl_float) // R11
    else $error("Control outputs floated unasked");
  property p_half_hold;
    @(posedge i_mclk) disable iff (!i_resetn)
      (half_mode && !sel_rise) |=> $stable(o_pclk);
  endproperty
  a_half_hold: assert property (p_half_hold) // R4
    else $error("Halved pixel clock moved off a source edge");
  property p_full_follow;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_ce && !half_mode) |=> o_pclk == $past(sel_now);
  endproperty
  a_full_follow: assert property (p_full_follow) // R3
    else $error("Pixel clock does not follow selected clock");
  property p_pixel_step;
    @(posedge i_mclk) disable iff (!i_resetn)
      !pclk_fall |=> $stable(o_pixel_bus_out);
  endproperty
  a_pixel_step: assert property (p_pixel_step) // R2
    else $error("Pixel bus changed off the falling pixel clock");
  property p_pixel_load;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_ce && pclk_fall) |=> o_pixel_take &&
        o_pixel_bus_out == $past(i_pixel);
  endproperty
  a_pixel_load: assert property (p_pixel_load) // R1
    else $error("Pixel not loaded");

endmodule

/* File: rtl/pdvo_pkg.sv */
// Constants, field layouts and carriers of the palette DAC video output
// Function
// R1 - Each pixel value leaves the block on an eight-bit bus toward the DAC.
// R2 - A pixel clock is driven out and the pixel bus changes in step with it.
// R3 - The pixel clock source is one of three video clocks, picked by a field.
// R4 - In the 320/360 wide modes the picked clock is halved, else passed as is.
// R5 - The palette read strobe is low only for I/O reads of 3C6H, 3C8H, 3C9H.
// R6 - The palette write strobe is low only for I/O writes of 3C6H to 3C9H.
// R7 - An active-low blank pulse goes to the monitor while display is blanked.
// R8 - Horizontal sync has its active level set by the horizontal polarity bit.
// R9 - Vertical sync has its active level set by the vertical polarity bit.
// R10 - Bit 5 of the fourth extended control register floats the pixel bus.
// R11 - Bit 6 of that register floats the blank and both sync outputs.
// R12 - Both palette strobes are never low together and rest high when idle.
package pdvo_pkg;

  // ****************************************************
  // Register bus
  // ****************************************************
  localparam int REG_AW = 4;
  localparam int REG_DW = 8;
  localparam logic [REG_AW-1:0] OFS_MISC_OUT = 4'h0;
  localparam logic [REG_AW-1:0] OFS_EXT_CTRL4 = 4'h4;
  localparam logic [REG_AW-1:0] OFS_MODE = 4'h8;
  localparam logic [REG_AW-1:0] OFS_STATUS = 4'hC;

  // ****************************************************
  // Field positions and reset values
  // ****************************************************
  localparam int MISC_CLK_LSB = 2;
  localparam int MISC_HPOL_BIT = 6;
  localparam int MISC_VPOL_BIT = 7;
  localparam int EXT_PIX_TRI_BIT = 5;
  localparam int EXT_CTL_TRI_BIT = 6;
  localparam int MODE_HALF_BIT = 0;
  localparam logic [REG_DW-1:0] MISC_OUT_RST = 8'h00;
  localparam logic [REG_DW-1:0] EXT_CTRL4_RST = 8'h00;
  localparam logic [REG_DW-1:0] MODE_RST = 8'h00;

  // ****************************************************
  // Clock select codes
  // ****************************************************
  localparam logic [1:0] CLK_SEL_A = 2'h0;
  localparam logic [1:0] CLK_SEL_B = 2'h1;
  localparam logic [1:0] CLK_SEL_C = 2'h2;

  // ****************************************************
  // Palette port addresses
  // ****************************************************
  localparam logic [15:0] PAL_MASK_ADDR = 16'h03C6;
  localparam logic [15:0] PAL_RIDX_ADDR = 16'h03C7;
  localparam logic [15:0] PAL_WIDX_ADDR = 16'h03C8;
  localparam logic [15:0] PAL_DATA_ADDR = 16'h03C9;

  // ****************************************************
  // Carriers
  // ****************************************************
  typedef struct packed {
    logic blank;
    logic hsync;
    logic vsync;
  } pdvo_timing_s;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
  } pdvo_io_s;

endpackage

/* File: verification/pdvo_dac_model.sv */
// Behavioural model of the external palette DAC at the pixel pins
`timescale 1ns/1ps
module pdvo_dac_model (
  // Pixel pins
  input wire logic i_pclk,
  input wire logic [7:0] i_pixel_pin,
  // Observation
  output int o_edges,
  output logic [7:0] o_latched
);
  initial begin
    o_edges = 0;
    o_latched = 8'h00;
  end

  // Latch on each rising pixel clock, as the real DAC does
  always @(posedge i_pclk) begin
    o_edges = o_edges + 1;
    o_latched <= i_pixel_pin;
  end
endmodule

/* File: verification/pdvo_video_out_test.sv */
// Self-checking bench for the palette DAC video output block
`timescale 1ns/1ps
module pdvo_video_out_test;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_ce = 1'b1;
  logic [pdvo_pkg::REG_AW-1:0] i_reg_addr = 4'h0;
  logic [pdvo_pkg::REG_DW-1:0] i_reg_wdata = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [pdvo_pkg::REG_DW-1:0] o_reg_rdata;
  logic vca = 1'b0;
  logic vcb = 1'b0;
  logic vcc = 1'b0;
  logic [7:0] i_pixel = 8'h00;
  pdvo_pkg::pdvo_timing_s i_timing = '0;
  pdvo_pkg::pdvo_io_s i_io = '0;
  logic o_pixel_take, o_pixel_oe, o_pclk, o_rd_n, o_wr_n;
  logic [7:0] o_pixel_bus_out, dac_pix;
  logic o_blank_out_n, o_hsync, o_vsync, o_ctl_oe;
  wire [7:0] pix_pin = o_pixel_oe ? o_pixel_bus_out : 8'hzz;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  int edges;
  int regs [4] = '{0, 0, 0, 0};
  logic [31:0] seed = 32'ha155;
  logic [31:0] pseed = 32'ha155;
  logic win = 1'b0;
  logic [7:0] last_pix = 8'h00;
  logic have_last = 1'b0;

  // ****************************************************
  // Clocks and instances
  // ****************************************************
  always #25 i_mclk = ~i_mclk;
  // Video clocks well below a quarter of the master clock
  always #201 vca = ~vca;
  always #301 vcb = ~vcb;
  always #401 vcc = ~vcc;

  pdvo_video_out #(.PIX_W(8)) u_pdvo_video_out (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(i_ce),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .i_video_clock_in_a(vca), .i_video_clock_in_b(vcb),
    .i_video_clock_in_c(vcc), .i_pixel(i_pixel), .i_timing(i_timing),
    .o_pixel_take(o_pixel_take), .i_io(i_io),
    .o_pixel_bus_out(o_pixel_bus_out), .o_pixel_oe(o_pixel_oe),
    .o_pclk(o_pclk), .o_palette_read_strobe_n(o_rd_n),
    .o_palette_write_strobe_n(o_wr_n), .o_blank_out_n(o_blank_out_n),
    .o_hsync(o_hsync), .o_vsync(o_vsync), .o_ctl_oe(o_ctl_oe));

  pdvo_dac_model u_pdvo_dac_model (
    .i_pclk(o_pclk), .i_pixel_pin(pix_pin), .o_edges(edges),
    .o_latched(dac_pix));

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    for (int i = 0; i < 8; i++) begin
      x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    end
    return x;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Model write is dropped while the clock enable is low
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    if (i_ce && a[1:0] == 2'b00 && a != 4'hC) begin
      regs[a[3:2]] = d;
    end
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
  endtask

  // Status only checked on its fixed top bits and idle strobes
  task automatic reg_rd(input logic [3:0] a);
    @(posedge i_mclk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_mclk);
    i_reg_rd <= 1'b0;
    @(negedge i_mclk);
    if (a == 4'hC) begin
      check(o_reg_rdata & 8'hF8, 8'h18);
    end else if (a[1:0] == 2'b00) begin
      check(o_reg_rdata, 8'(regs[a[3:2]]));
    end else begin
      check(o_reg_rdata, 8'h00);
    end
  endtask

  // ****************************************************
  // Pixel bus follows the captured pixel
  // ****************************************************
  always @(negedge i_mclk) begin
    if (win && o_pixel_take === 1'b1) begin
      check(o_pixel_bus_out, i_pixel);
      // The DAC must have latched the previous pixel on the rise between
      if (have_last) begin
        check(dac_pix, last_pix);
      end
      last_pix = i_pixel;
      have_last = 1'b1;
    end else if (!win) begin
      have_last = 1'b0;
    end
  end

  // New pixel only after the previous one was taken
  always @(posedge i_mclk) begin
    if (win && o_pixel_take === 1'b1) begin
      pseed = lfsr(pseed);
      i_pixel <= pseed[7:0];
    end
  end

  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    int per, exp, d, n0;
    logic exp_rd, exp_wr;
    repeat (4) @(posedge i_mclk);
    @(negedge i_mclk);
    check(o_rd_n, 1'b1);
    check(o_wr_n, 1'b1);
    check(o_blank_out_n, 1'b1);
    @(posedge i_mclk);
    i_resetn <= 1'b1;
    reg_wr(4'h2, 8'h5A);
    reg_rd(4'h2);
    reg_wr(pdvo_pkg::OFS_STATUS, 8'hFF);
    reg_rd(pdvo_pkg::OFS_STATUS);
    reg_wr(pdvo_pkg::OFS_MODE, 8'h01);
    reg_rd(pdvo_pkg::OFS_MODE);
    @(posedge i_mclk);
    i_ce <= 1'b0;
    reg_wr(pdvo_pkg::OFS_MODE, 8'h00);
    @(posedge i_mclk);
    i_ce <= 1'b1;
    reg_rd(pdvo_pkg::OFS_MODE);
    reg_wr(pdvo_pkg::OFS_MODE, 8'h00);
    // Every address near the palette ports, read, write and both
    for (int a = 16'h03C5; a <= 16'h03CA; a++) begin
      for (int m = 1; m <= 3; m++) begin
        @(posedge i_mclk);
        i_io <= '{addr: 16'(a), rd: m[1], wr: m[0]};
        @(posedge i_mclk);
        @(negedge i_mclk);
        exp_rd = m == 2 && (a == 16'h03C6 || a == 16'h03C8 || a == 16'h03C9);
        exp_wr = m == 1 && a >= 16'h03C6 && a <= 16'h03C9;
        check(o_rd_n, !exp_rd);
        check(o_wr_n, !exp_wr);
        @(posedge i_mclk);
        i_io <= '0;
        @(posedge i_mclk);
        @(negedge i_mclk);
        check({o_rd_n, o_wr_n}, 8'h03);
      end
    end
    // Polarity, blank and float bits from random settings
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      reg_wr(pdvo_pkg::OFS_MISC_OUT, {seed[1:0], 6'h00});
      reg_wr(pdvo_pkg::OFS_EXT_CTRL4, {1'b0, seed[3:2], 5'h00});
      @(posedge i_mclk);
      i_timing <= seed[6:4];
      @(posedge i_mclk);
      @(negedge i_mclk);
      check(o_blank_out_n, !seed[6]);
      check(o_hsync, seed[5] ^ regs[0][6]);
      check(o_vsync, seed[4] ^ regs[0][7]);
      check(o_pixel_oe, !regs[1][5]);
      check(o_ctl_oe, !regs[1][6]);
    end
    reg_wr(pdvo_pkg::OFS_EXT_CTRL4, 8'h00);
    // Each clock select code, undivided and halved
    for (int s = 0; s < 8; s++) begin
      reg_wr(pdvo_pkg::OFS_MISC_OUT, {4'h0, s[1:0], 2'h0});
      reg_wr(pdvo_pkg::OFS_MODE, {7'h00, s[2]});
      repeat (20) @(posedge i_mclk);
      n0 = edges;
      win <= 1'b1;
      repeat (480) @(posedge i_mclk);
      win <= 1'b0;
      per = (s[1:0] == 1) ? 602 : (s[1:0] == 2) ? 802 : 402;
      exp = 24000 / per / (s[2] ? 2 : 1);
      d = edges - n0 - exp;
      check(8'(d >= -1 && d <= 1), 8'h01);
    end
    close_out();
  end
endmodule
